// *** inc/sensor_status_turns_pkg.sv ***
// constants for the sensor status, temperature, field and rotation registers
package sensor_status_turns_pkg;
    localparam logic [7:0] WARN_OFFSET = 8'h26;
    localparam logic [7:0] TEMP_OFFSET = 8'h28;
    localparam logic [7:0] FIELD_OFFSET = 8'h2a;
    localparam logic [7:0] TURNS_OFFSET = 8'h2c;
    localparam logic [7:0] FRAC_OFFSET = 8'h2e;
    localparam logic [3:0] WARN_TAG = 4'hb;
    localparam logic [3:0] TEMP_TAG = 4'hf;
    localparam logic [3:0] FIELD_TAG = 4'he;
    localparam logic [1:0] TURNS_TAG = 2'h3;
    localparam logic FRAC_TAG = 1'b1;
    // warning bit positions in the low half of the warning register
    localparam int TEMP_RANGE_BIT = 6;
    localparam int EEPROM_CORR_BIT = 5;
    localparam int SAT_BIT = 4;
    localparam int STEP_BIT = 3;
    localparam int OVERRUN_BIT = 2;
    localparam int FIELD_HIGH_BIT = 1;
    localparam int OVERFLOW_BIT = 0;
    localparam int WARN_BITS = 7;
    // temperature limits in eighths of a degree relative to 25 C
    localparam logic signed [15:0] TEMP_MIN = 16'shfd58;
    localparam logic signed [15:0] TEMP_MAX = 16'sh04d8;
    // 135 degrees in 4096ths of a turn
    localparam int STEP_DEG = 135;
    localparam logic [11:0] STEP_LIMIT = 12'((STEP_DEG * 4096) / 360);
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int UPDATE_PERIOD_NS = 64000;
    localparam int FIELD_PERIOD_NS = 128000;
    localparam int UPDATE_CYCLES = UPDATE_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int FIELD_CYCLES = FIELD_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam int ACCUM_BITS = 21;
endpackage

// *** hdl/sensor_status_turns_regs.sv ***
// status, temperature, field and rotation counter registers of the angle sensor
`timescale 1ns/1ps
module sensor_status_turns_regs #(
    parameter int SAT_SOURCES = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic signed [15:0] temp_raw,
    input wire logic [11:0] field_gauss,
    input wire logic [11:0] field_high_limit,
    input wire logic [SAT_SOURCES-1:0] sat_sources,
    input wire logic eeprom_load_done,
    input wire logic eeprom_single_err,
    input wire logic ext_start,
    input wire logic ext_done,
    input wire logic [11:0] angle_pll,
    input wire logic [11:0] angle_zcd,
    input wire logic rotation_source_select,
    input wire logic eighth_turn_resolution,
    input wire logic [6:0] warn_mask,
    input wire logic err_unmasked_any,
    input wire logic warn_upper_unmasked_any,
    output logic error_summary
);

    localparam int AB = sensor_status_turns_pkg::ACCUM_BITS;

    // odd parity bit over the fifteen other bits of a word
    function automatic logic odd_parity(input logic [14:0] bits);
        odd_parity = ~(^bits);
    endfunction

    function automatic logic [15:0] turns_word(input logic src, input logic [11:0] cnt);
        logic [14:0] rest;
        rest = {sensor_status_turns_pkg::TURNS_TAG, src, cnt};
        turns_word = {rest[14:12], odd_parity(rest), rest[11:0]};
    endfunction

    // update and field refresh ticks
    logic [10:0] upd_cnt_q;
    logic [10:0] fld_cnt_q;
    logic upd_tick;
    logic fld_tick;

    assign upd_tick = (upd_cnt_q == 11'(sensor_status_turns_pkg::UPDATE_CYCLES - 1));
    assign fld_tick = (fld_cnt_q == 11'(sensor_status_turns_pkg::FIELD_CYCLES - 1));

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            upd_cnt_q <= 11'h000;
        end else if (upd_tick) begin
            upd_cnt_q <= 11'h000;
        end else begin
            upd_cnt_q <= upd_cnt_q + 11'h001;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fld_cnt_q <= 11'h000;
        end else if (fld_tick) begin
            fld_cnt_q <= 11'h000;
        end else begin
            fld_cnt_q <= fld_cnt_q + 11'h001;
        end
    end

    // temperature clamp
    logic temp_low;
    logic temp_high;
    logic [11:0] temp_d;
    logic [11:0] temp_q;

    assign temp_low = temp_raw < sensor_status_turns_pkg::TEMP_MIN;
    assign temp_high = temp_raw > sensor_status_turns_pkg::TEMP_MAX;

    always_comb begin
        if (temp_low) begin
            temp_d = sensor_status_turns_pkg::TEMP_MIN[11:0];
        end else if (temp_high) begin
            temp_d = sensor_status_turns_pkg::TEMP_MAX[11:0];
        end else begin
            temp_d = temp_raw[11:0];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            temp_q <= 12'h000;
        end else begin
            temp_q <= temp_d;
        end
    end

    // field strength sampled once per refresh period
    logic [11:0] field_q;
    logic field_high;

    assign field_high = fld_tick && (field_gauss > field_high_limit);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            field_q <= 12'h000;
        end else if (fld_tick) begin
            field_q <= field_gauss;
        end
    end

    // extended access tracking
    logic ext_busy_q;
    logic ext_overrun;

    assign ext_overrun = ext_start && ext_busy_q && !ext_done;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ext_busy_q <= 1'b0;
        end else if (ext_start) begin
            ext_busy_q <= 1'b1;
        end else if (ext_done) begin
            ext_busy_q <= 1'b0;
        end
    end

    // absolute position accumulator, 4096 steps per rotation
    logic [11:0] angle_sel;
    logic [11:0] angle_prev_q;
    logic have_prev_q;
    logic [11:0] step;
    logic [11:0] step_abs;
    logic [AB:0] sum;
    logic [AB-1:0] accum_q;
    logic step_big;
    logic accum_ovf;

    // a late update from the slower path is tolerated: counting follows the select live
    assign angle_sel = rotation_source_select ? angle_pll : angle_zcd;
    assign step = angle_sel - angle_prev_q;
    assign step_abs = step[11] ? (12'h000 - step) : step;
    assign step_big = upd_tick && have_prev_q && (step_abs > sensor_status_turns_pkg::STEP_LIMIT);
    assign sum = {accum_q[AB-1], accum_q} + {{(AB - 11){step[11]}}, step};
    // leaving the 21-bit signed range means reaching +256 or passing -256 rotations
    assign accum_ovf = upd_tick && have_prev_q && (sum[AB] != sum[AB-1]);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            angle_prev_q <= 12'h000;
            have_prev_q <= 1'b0;
        end else if (upd_tick) begin
            angle_prev_q <= angle_sel;
            have_prev_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            accum_q <= '0;
        end else if (upd_tick && have_prev_q) begin
            accum_q <= sum[AB-1:0];
        end
    end

    // rotation count and fraction views of the accumulator
    logic [11:0] turns_cnt;
    logic [10:0] frac_now;

    always_comb begin
        if (eighth_turn_resolution) begin
            turns_cnt = accum_q[20:9];
            frac_now = {2'h0, accum_q[8:0]};
        end else begin
            turns_cnt = {{2{accum_q[20]}}, accum_q[20:11]};
            frac_now = accum_q[10:0];
        end
    end

    // warning flags
    logic [6:0] warn_set;
    logic [6:0] warn_clr;
    logic [6:0] warn_q;

    always_comb begin
        warn_set = 7'h00;
        warn_set[sensor_status_turns_pkg::TEMP_RANGE_BIT] = temp_low || temp_high;
        warn_set[sensor_status_turns_pkg::EEPROM_CORR_BIT] = eeprom_load_done && eeprom_single_err;
        warn_set[sensor_status_turns_pkg::SAT_BIT] = |sat_sources;
        warn_set[sensor_status_turns_pkg::STEP_BIT] = step_big;
        warn_set[sensor_status_turns_pkg::OVERRUN_BIT] = ext_overrun;
        warn_set[sensor_status_turns_pkg::FIELD_HIGH_BIT] = field_high;
        warn_set[sensor_status_turns_pkg::OVERFLOW_BIT] = accum_ovf;
    end

    // write one to clear
    assign warn_clr = (reg_wr && reg_addr == sensor_status_turns_pkg::WARN_OFFSET) ?
        reg_wdata[6:0] : 7'h00;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            warn_q <= 7'h00;
        end else begin
            // a new event wins over a clear in the same cycle
            warn_q <= (warn_q & ~warn_clr) | warn_set;
        end
    end

    logic summary_d;

    assign summary_d = err_unmasked_any || warn_upper_unmasked_any || |(warn_q & ~warn_mask);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            error_summary <= 1'b0;
        end else begin
            error_summary <= summary_d;
        end
    end

    // fraction capture on a count read
    logic turns_rd;
    logic frac_rd;
    logic [10:0] frac_q;
    logic lat_q;

    assign turns_rd = reg_rd && (reg_addr == sensor_status_turns_pkg::TURNS_OFFSET);
    assign frac_rd = reg_rd && (reg_addr == sensor_status_turns_pkg::FRAC_OFFSET);

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            frac_q <= 11'h000;
        end else if (turns_rd) begin
            frac_q <= frac_now;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            lat_q <= 1'b0;
        end else if (turns_rd) begin
            lat_q <= 1'b1;
        end else if (frac_rd) begin
            lat_q <= 1'b0;
        end
    end

    // read mux
    logic [15:0] rdata_d;
    logic [14:0] frac_rest;

    assign frac_rest = {sensor_status_turns_pkg::FRAC_TAG, lat_q, 1'b0, 1'b0, frac_q};

    always_comb begin
        case (reg_addr)
            sensor_status_turns_pkg::WARN_OFFSET: begin
                rdata_d = {sensor_status_turns_pkg::WARN_TAG, 5'h00, warn_q};
            end
            sensor_status_turns_pkg::TEMP_OFFSET: begin
                rdata_d = {sensor_status_turns_pkg::TEMP_TAG, temp_q};
            end
            sensor_status_turns_pkg::FIELD_OFFSET: begin
                rdata_d = {sensor_status_turns_pkg::FIELD_TAG, field_q};
            end
            sensor_status_turns_pkg::TURNS_OFFSET: begin
                rdata_d = turns_word(rotation_source_select, turns_cnt);
            end
            sensor_status_turns_pkg::FRAC_OFFSET: begin
                rdata_d = {frac_rest[14:12], odd_parity(frac_rest), frac_rest[11:0]};
            end
            default: begin
                rdata_d = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

endmodule

// *** tb/host_model.sv ***
// host side model driving the register port of the status block
`timescale 1ns/1ps
module host_model (
    input wire logic clock,
    input wire logic [15:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        {reg_wr, reg_rd} = 2'b00;
    end
    // flags only clear by writing ones back, the extra edge keeps strobes apart
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        d = reg_rdata;
    endtask
endmodule

// *** tb/turns_regs_checker.sv ***
// port assertions for the status and rotation register block
`timescale 1ns/1ps
module turns_regs_checker #(
    parameter int SAT_SOURCES = 4
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic signed [15:0] temp_raw,
    input wire logic [SAT_SOURCES-1:0] sat_sources,
    input wire logic [6:0] warn_mask,
    input wire logic err_unmasked_any,
    input wire logic warn_upper_unmasked_any,
    input wire logic rotation_source_select,
    input wire logic error_summary
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic rd_temp;
    logic rd_field;
    logic rd_turns;
    logic rd_frac;
    assign rd_temp = reg_rd && reg_addr == 8'h28;
    assign rd_field = reg_rd && reg_addr == 8'h2a;
    assign rd_turns = reg_rd && reg_addr == 8'h2c;
    assign rd_frac = reg_rd && reg_addr == 8'h2e;
    idle_zero_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    temp_tag_a: assert property (rd_temp |=> reg_rdata[15:12] == 4'hf)
        else $error("temperature tag wrong");
    // the register lags the raw input by one cycle, so the clamp follows the past value
    temp_high_a: assert property (
        rd_temp && $past(temp_raw) > 16'sd1240 |=> reg_rdata == 16'hf4d8)
        else $error("temperature not clamped high");
    temp_low_a: assert property (
        rd_temp && $past(temp_raw) < -16'sd680 |=> reg_rdata == 16'hfd58)
        else $error("temperature not clamped low");
    field_tag_a: assert property (rd_field |=> reg_rdata[15:12] == 4'he)
        else $error("field tag wrong");
    turns_word_a: assert property (
        rd_turns |=> reg_rdata[15:14] == 2'b11 && ^reg_rdata
        && reg_rdata[13] == $past(rotation_source_select))
        else $error("count word tag, source or parity wrong");
    frac_word_a: assert property (
        rd_frac |=> reg_rdata[15] && !reg_rdata[13] && !reg_rdata[11] && ^reg_rdata)
        else $error("fraction word tag, zero bits or parity wrong");
    sat_summary_a: assert property (|sat_sources && !warn_mask[4] |-> ##[1:2] error_summary)
        else $error("saturation not reported");
    summary_set_a: assert property (
        err_unmasked_any || warn_upper_unmasked_any |-> ##[1:2] error_summary)
        else $error("summary missing");
    summary_quiet_a: assert property (
        (!err_unmasked_any && !warn_upper_unmasked_any && &warn_mask) [*2] |-> !error_summary)
        else $error("summary set with all masked");
    cover property (rd_turns ##[1:4] rd_frac);
    cover property (rd_temp && temp_raw < -16'sd680);
    cover property ($rose(error_summary));
endmodule
bind sensor_status_turns_regs turns_regs_checker #(.SAT_SOURCES(SAT_SOURCES)) i_chk (.*);

// *** tb/tb_top.sv ***
// self-checking bench for the status, temperature, field and rotation registers
`timescale 1ns/1ps
module tb_top;
    logic clock, rst_b, reg_wr, reg_rd, eeprom_load_done, eeprom_single_err, ext_start, ext_done;
    logic src, t45, err_any, upper_any, error_summary;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic signed [15:0] temp_raw;
    logic [11:0] field_gauss, field_high_limit, angle;
    logic [3:0] sat_sources;
    logic [6:0] warn_mask;
    int fail_count, samples_checked;
    host_model i_host (.*);
    // the slower path sees the angle mirrored, so a wrong source select shows in the count
    sensor_status_turns_regs i_dut (.*, .angle_pll(angle), .angle_zcd(12'h000 - angle),
        .rotation_source_select(src), .eighth_turn_resolution(t45),
        .err_unmasked_any(err_any), .warn_upper_unmasked_any(upper_any));
    function automatic logic [15:0] par(logic [15:0] w);
        return w | (16'(~^w) << 12);
    endfunction
    function automatic logic [15:0] temp_word(logic signed [15:0] t);
        logic signed [15:0] c;
        c = t > 16'sd1240 ? 16'sd1240 : (t < -16'sd680 ? -16'sd680 : t);
        return {4'hf, c[11:0]};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        i_host.rd(a, d);
        chk(d, e);
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // a hung step must still reach the verdict
    initial begin
        repeat (100000) @(posedge clock);
        fail_count++;
        stop_test();
    end
    initial begin
        int acc, s;
        logic [20:0] a;
        logic [10:0] f;
        logic signed [15:0] tv [10];
        logic [11:0] fv [3];
        logic [7:0] un [3];
        logic [11:0] pa, nx, sel;
        un = '{8'h00, 8'h27, 8'h30};
        {rst_b, eeprom_load_done, eeprom_single_err, ext_start, ext_done} = 5'b0;
        {err_any, upper_any, src, t45} = 4'b0011;
        {temp_raw, field_gauss, angle, sat_sources, warn_mask} = '0;
        field_high_limit = 12'd1344;
        void'($urandom(32'h6381));
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rc(8'h2c, 16'he000);
        rc(8'h2e, par(16'hc000));
        rc(8'h2e, par(16'h8000));
        i_host.wr(8'h28, 16'h0123);
        foreach (un[i]) rc(un[i], 16'h0000);
        tv = '{-16'sd681, -16'sd680, 16'sd1240, 16'sd1241, 0, 0, 0, 0, 0, 0};
        for (int i = 0; i < 10; i++) begin
            tv[i] = i > 3 ? 16'($urandom_range(0, 4095)) - 16'sd2048 : tv[i];
            temp_raw <= tv[i];
            repeat (2) @(posedge clock);
            rc(8'h28, temp_word(tv[i]));
        end
        temp_raw <= 16'sd0;
        rc(8'h26, 16'hb040);
        chk(16'(error_summary), 16'h0001);
        i_host.wr(8'h26, 16'h0040);
        rc(8'h26, 16'hb000);
        sat_sources <= 4'($urandom_range(1, 15));
        {eeprom_load_done, eeprom_single_err, ext_start} <= 3'b111;
        @(posedge clock);
        {sat_sources, eeprom_load_done} <= 5'h00;
        @(posedge clock);
        {ext_start, ext_done, eeprom_single_err} <= 3'b010;
        @(posedge clock);
        ext_done <= 1'b0;
        rc(8'h26, 16'hb034);
        warn_mask <= 7'h7f;
        repeat (3) @(posedge clock);
        chk(16'(error_summary), 16'h0000);
        for (int i = 0; i < 2; i++) begin
            {upper_any, err_any} <= 2'(i + 1);
            repeat (2) @(posedge clock);
            chk(16'(error_summary), 16'h0001);
        end
        {upper_any, err_any, warn_mask} <= 9'h000;
        i_host.wr(8'h26, 16'h007f);
        rc(8'h26, 16'hb000);
        fv = '{12'd1345, 12'd1344, 12'd0};
        for (int i = 0; i < 4; i++) begin
            fv[i % 3] = i == 2 ? 12'($urandom_range(0, 4095)) : fv[i % 3];
            field_gauss <= i == 3 ? 12'h000 : fv[i % 3];
            repeat (1300) @(posedge clock);
            i_host.wr(8'h26, 16'h007f);
            repeat (1300) @(posedge clock);
            rc(8'h2a, {4'he, field_gauss});
            rc(8'h26, field_gauss > 12'd1344 ? 16'hb002 : 16'hb000);
        end
        acc = 0;
        pa = 12'h000;
        for (int i = 0; i < 8; i++) begin
            s = i == 7 ? 2000 : int'($urandom_range(0, 3000)) - 1500;
            nx = angle + 12'(s);
            // only the selected path moves the count, measured from the last sample of whichever path was selected before
            sel = i[1] ? nx : 12'h000 - nx;
            acc += int'(signed'(sel - pa));
            pa = sel;
            angle <= nx;
            {src, t45} <= 2'(i);
            repeat (700) @(posedge clock);
            a = 21'(acc);
            f = t45 ? {2'b00, a[8:0]} : a[10:0];
            rc(8'h2c, par({2'b11, src, 1'b0, t45 ? a[20:9] : {{2{a[20]}}, a[20:11]}}));
            rc(8'h2e, par({2'b11, 3'b000, f}));
            rc(8'h2e, par({1'b1, 4'b0000, f}));
        end
        rc(8'h26, 16'hb008);
        stop_test();
    end
endmodule
